// file: verilog/fcp_ctrl.sv
// Flash command sequencer with protection, APB register slave
// Overview of operation
// RQ1 - Command 0x01 loads the addressed flash word into the data register.
// RQ2 - Command 0x02 programs the data register at the address, about 50 us.
// RQ3 - Command 0x03 erases the page then programs the word, about 20 ms.
// RQ4 - Command 0x04 compares flash word with data, result in status bit 1.
// RQ5 - Command 0x05 erases only the addressed page.
// RQ6 - Command 0x06 erases user space, kernel kept, about 2.48 s.
// RQ7 - Mass erase runs only after the unlock sequence, else refused.
// RQ8 - Software loads 0x3CFF, 0xFFC3, sets mode bit 0x8, then 0x06.
// RQ9 - Command 0x0B builds a 24-bit signature over 64 kB in 32778 cycles.
// RQ10 - Command 0x0C commits deferred protection once; key or mass erase undo.
// RQ11 - Command 0x0F touches no flash but still raises completion.
// RQ12 - Software never issues codes 0x07 to 0x0A, 0x0D, 0x0E.
// RQ13 - A reserved code never modifies the flash array.
// RQ14 - After commands null to mass erase the command register reads 0x07.
// RQ15 - Block 0 protection bit 31 low blocks reads of block 0.
// RQ16 - Block 0 bits 30..0 gate writes to four-page groups.
// RQ17 - Block 1 protection bit 31 low blocks reads of block 1.
// RQ18 - Block 1 bit 30 low blocks writes to pages 127 to 120.
// RQ19 - Block 1 bits 29..0 gate writes to four-page groups.
// RQ20 - Immediate protection acts at once; deferred needs key and commit.
// RQ21 - Status: busy bit 2, fail 1, done 0, irq 3; read clears 0,1,3.
// RQ22 - Erase and write need mode bit 3; mode bit 4 enables interrupt.
module fcp_ctrl #(
    parameter int unsigned ERWR_CYC = 200000,
    parameter int unsigned MASS_CYC = 24800000,
    parameter int unsigned SIG_CYC  = 32778
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Flash array
    output logic             fl_rd,
    output logic             fl_prog,
    output logic             fl_erase_pg,
    output logic             fl_erase_all,
    output logic             fl_blk,
    output logic      [14:0] fl_addr,
    output logic      [15:0] fl_wdata,
    input  wire logic [15:0] fl_rdata
);
    // ========================================================
    // Helpers
    function automatic logic mapped(input logic [6:0] o);
        case (o)
            fcp_pkg::OFS_STA, fcp_pkg::OFS_MOD, fcp_pkg::OFS_CON,
            fcp_pkg::OFS_DAT, fcp_pkg::OFS_ADR, fcp_pkg::OFS_SGN,
            fcp_pkg::OFS_PRO, fcp_pkg::OFS_HID: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    // Page write gate: four pages per bit, block 1 top group wider
    function automatic logic page_ok(input logic b, input logic [6:0] pg,
                                     input logic [31:0] pr);
        if (!b && pg >= fcp_pkg::KERN_PG)
            page_ok = 1'b0;                                  // RQ16
        else if (b && pg >= fcp_pkg::TOP1_PG)
            page_ok = pr[fcp_pkg::PRO_TOP1];                 // RQ18
        else
            page_ok = pr[pg[6:2]];                           // RQ16 RQ19
    endfunction : page_ok

    fcp_pkg::fcp_state_e st_q;
    logic [24:0] cnt_q;
    logic [15:0] wcnt_q;
    logic [7:0]  mod_q, cmd_q;
    logic [15:0] dat_q, adr_q;
    logic [23:0] sgn_q, sig_acc_q;
    logic [31:0] pro_q [2];
    logic [31:0] hid_q [2];
    logic [31:0] act_q [2];
    logic [1:0]  lock_q;
    logic [31:0] key_q [2];
    logic        blk_q, fail_q, rd_d1_q, pready_q;
    logic        sta_done_q, sta_fail_q, sta_irq_q;

    // ========================================================
    // Bus decode
    logic [6:0]  ofs;
    logic        bank, hit, busy, take, acc, wr, start, rd_clr;
    logic [31:0] rd_val, prot;
    logic [7:0]  code;
    logic        rd_ok, wr_ok, key_ok, verify_bad;

    assign ofs   = paddr[6:0];
    assign bank  = paddr[fcp_pkg::BANK_BIT];
    assign hit   = (paddr[11:8] == 4'h0) && mapped(ofs);
    assign busy  = (st_q != fcp_pkg::S_IDLE);
    assign take  = psel && penable && !pready_q;
    assign acc   = psel && penable && pready_q && hit;
    assign wr    = acc && pwrite;
    assign code  = pwdata[7:0];
    assign start = wr && (ofs == fcp_pkg::OFS_CON) && !busy;
    assign rd_clr = take && !pwrite && hit && (ofs == fcp_pkg::OFS_STA);

    // Immediate register acts at once, deferred only once committed
    assign prot  = hid_q[bank] & act_q[bank];                // RQ20
    assign rd_ok = prot[fcp_pkg::PRO_RD];                    // RQ15 RQ17
    assign wr_ok = mod_q[fcp_pkg::MOD_EW] &&                 // RQ22
                   page_ok(bank, adr_q[15:9], prot);
    assign key_ok = mod_q[fcp_pkg::MOD_EW] &&                // RQ7 RQ8
                    dat_q == fcp_pkg::MASS_DAT &&
                    adr_q == fcp_pkg::MASS_ADR;
    assign verify_bad = (fl_rdata != dat_q);

    always_comb begin
        rd_val = 32'h00000000;
        case (ofs)
            fcp_pkg::OFS_STA: rd_val[3:0] = {sta_irq_q, busy,   // RQ21
                                             sta_fail_q, sta_done_q};
            fcp_pkg::OFS_MOD: rd_val[7:0]  = mod_q;
            fcp_pkg::OFS_CON: rd_val[7:0]  = cmd_q;
            fcp_pkg::OFS_DAT: rd_val[15:0] = dat_q;
            fcp_pkg::OFS_ADR: rd_val[15:0] = adr_q;
            fcp_pkg::OFS_SGN: rd_val[23:0] = sgn_q;
            fcp_pkg::OFS_PRO: rd_val = pro_q[bank];
            fcp_pkg::OFS_HID: rd_val = hid_q[bank];
            default:          rd_val = 32'h00000000;
        endcase
    end

    // One wait state: read data is caught when pready rises
    always_ff @(posedge clock) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h00000000;
        end else begin
            pready_q <= take;
            pslverr  <= take && (!hit || (pwrite && busy &&
                        (ofs == fcp_pkg::OFS_CON ||
                         ofs == fcp_pkg::OFS_DAT ||
                         ofs == fcp_pkg::OFS_ADR)));
            if (take && !pwrite)
                prdata <= hit ? rd_val : 32'h00000000;
        end
    end
    assign pready = pready_q;

    // ========================================================
    // Software registers
    always_ff @(posedge clock) begin
        if (srst) begin
            mod_q <= fcp_pkg::MOD_RST;
            adr_q <= fcp_pkg::ADR_RST;
        end else if (wr && !busy) begin
            if (ofs == fcp_pkg::OFS_MOD)
                mod_q <= pwdata[7:0];
            if (ofs == fcp_pkg::OFS_ADR)
                adr_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst)
            dat_q <= 16'h0000;
        else if (st_q == fcp_pkg::S_RUN && cnt_q == 25'd0 &&
                 cmd_q == fcp_pkg::CMD_READ)
            dat_q <= fl_rdata;                               // RQ1
        else if (wr && !busy && ofs == fcp_pkg::OFS_DAT)
            dat_q <= pwdata[15:0];
    end

    // ========================================================
    // Protection: commit once, undo by key or mass erase
    always_ff @(posedge clock) begin
        if (srst) begin
            for (int i = 0; i < 2; i++) begin
                pro_q[i] <= fcp_pkg::PRO_RST;
                hid_q[i] <= fcp_pkg::HID_RST;
                act_q[i] <= fcp_pkg::OPEN_ALL;
                key_q[i] <= 32'h00000000;
            end
            lock_q <= 2'b00;
        end else begin
            if (wr && ofs == fcp_pkg::OFS_PRO)
                pro_q[bank] <= pwdata;
            if (wr && ofs == fcp_pkg::OFS_HID)
                hid_q[bank] <= pwdata;                       // RQ20
            if (start && code == fcp_pkg::CMD_PROT) begin
                if (!lock_q[bank]) begin
                    act_q[bank]  <= pro_q[bank];             // RQ10
                    key_q[bank]  <= {adr_q, dat_q};
                    lock_q[bank] <= 1'b1;
                end else if (key_q[bank] == {adr_q, dat_q}) begin
                    act_q[bank]  <= fcp_pkg::OPEN_ALL;       // RQ10
                    lock_q[bank] <= 1'b0;
                end
            end
            if (st_q == fcp_pkg::S_FIN && cmd_q == fcp_pkg::CMD_MASS &&
                !fail_q) begin
                act_q[blk_q]  <= fcp_pkg::OPEN_ALL;          // RQ10
                lock_q[blk_q] <= 1'b0;
            end
        end
    end

    // ========================================================
    // Sequencer
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= fcp_pkg::S_IDLE;
            cnt_q <= 25'd0;
            cmd_q <= fcp_pkg::CON_RST;
            fail_q <= 1'b0;
            blk_q <= 1'b0;
        end else begin
            case (st_q)
                fcp_pkg::S_IDLE: begin
                    if (start) begin
                        cmd_q <= code;
                        blk_q <= bank;
                        fail_q <= 1'b0;
                        st_q <= fcp_pkg::S_RUN;
                        cnt_q <= 25'd0;
                        case (code)
                            fcp_pkg::CMD_READ,
                            fcp_pkg::CMD_VERIFY: begin
                                fail_q <= !rd_ok;            // RQ15 RQ17
                                cnt_q <= 25'd1;
                            end
                            fcp_pkg::CMD_WRITE: begin
                                fail_q <= !wr_ok;            // RQ22
                                cnt_q <= 25'(fcp_pkg::WRITE_CYC - 1);
                            end
                            fcp_pkg::CMD_ERWR,
                            fcp_pkg::CMD_ERASE: begin
                                fail_q <= !wr_ok;            // RQ22
                                cnt_q <= 25'(ERWR_CYC - 1);
                            end
                            fcp_pkg::CMD_MASS: begin
                                fail_q <= !key_ok;           // RQ7
                                cnt_q <= 25'(MASS_CYC - 1);
                            end
                            fcp_pkg::CMD_SIGN: begin
                                st_q <= fcp_pkg::S_SIGN;     // RQ9
                                cnt_q <= 25'(SIG_CYC - 1);
                            end
                            fcp_pkg::CMD_PROT:
                                fail_q <= lock_q[bank] &&
                                    key_q[bank] != {adr_q, dat_q};
                            fcp_pkg::CMD_NULL,
                            fcp_pkg::CMD_PING:
                                fail_q <= 1'b0;              // RQ11
                            default:
                                fail_q <= 1'b1;              // RQ13
                        endcase
                    end
                end
                fcp_pkg::S_RUN, fcp_pkg::S_SIGN: begin
                    // A refused command ends at once
                    if (cnt_q == 25'd0 || fail_q) begin
                        st_q <= fcp_pkg::S_FIN;
                        if (cmd_q == fcp_pkg::CMD_VERIFY && !fail_q)
                            fail_q <= verify_bad;            // RQ4
                    end else
                        cnt_q <= cnt_q - 25'd1;
                end
                fcp_pkg::S_FIN: begin
                    st_q <= fcp_pkg::S_IDLE;
                    cmd_q <= (cmd_q <= fcp_pkg::CMD_MASS) ?  // RQ14
                             fcp_pkg::CMD_DONE : fcp_pkg::CON_RST;
                end
                default: st_q <= fcp_pkg::S_IDLE;
            endcase
        end
    end

    // ========================================================
    // Flash strobes: one-cycle pulses for accepted commands, fl_rd held high while signing reads the SIG_WORDS words
    always_ff @(posedge clock) begin
        if (srst) begin
            fl_rd <= 1'b0;
            fl_prog <= 1'b0;
            fl_erase_pg <= 1'b0;
            fl_erase_all <= 1'b0;
            fl_blk <= 1'b0;
            fl_addr <= 15'h0000;
            fl_wdata <= 16'h0000;
            rd_d1_q <= 1'b0;
        end else begin
            fl_rd <= 1'b0;
            fl_prog <= 1'b0;
            fl_erase_pg <= 1'b0;
            fl_erase_all <= 1'b0;
            rd_d1_q <= fl_rd;
            if (start) begin
                fl_blk <= bank;
                fl_addr <= adr_q[15:1];
                fl_wdata <= dat_q;
                case (code)
                    fcp_pkg::CMD_READ,
                    fcp_pkg::CMD_VERIFY: fl_rd <= rd_ok;      // RQ1 RQ4
                    fcp_pkg::CMD_WRITE:  fl_prog <= wr_ok;    // RQ2
                    fcp_pkg::CMD_ERWR: begin
                        fl_erase_pg <= wr_ok;                // RQ3
                        fl_prog <= wr_ok;
                    end
                    fcp_pkg::CMD_ERASE: fl_erase_pg <= wr_ok; // RQ5
                    fcp_pkg::CMD_MASS: fl_erase_all <= key_ok; // RQ6
                    default: fl_rd <= 1'b0;                  // RQ13
                endcase
            end else if (st_q == fcp_pkg::S_SIGN &&
                         wcnt_q < fcp_pkg::SIG_WORDS) begin
                fl_rd <= 1'b1;                               // RQ9
                fl_addr <= wcnt_q[14:0];
            end
        end
    end

    // Signature: rotate-and-fold of every word of the block
    always_ff @(posedge clock) begin
        if (srst) begin
            wcnt_q <= 16'h0000;
            sig_acc_q <= fcp_pkg::SGN_RST;
            sgn_q <= fcp_pkg::SGN_RST;
        end else if (start) begin
            wcnt_q <= 16'h0000;
            sig_acc_q <= fcp_pkg::SGN_RST;
        end else if (st_q == fcp_pkg::S_SIGN) begin
            if (wcnt_q < fcp_pkg::SIG_WORDS)
                wcnt_q <= wcnt_q + 16'h0001;
            if (rd_d1_q)
                sig_acc_q <= {sig_acc_q[22:0], sig_acc_q[23]} ^
                             {8'h00, fl_rdata};
            if (cnt_q == 25'd0)
                sgn_q <= sig_acc_q;                          // RQ9
        end
    end

    // ========================================================
    // Status flags: a completion in the read cycle is kept
    always_ff @(posedge clock) begin
        if (srst) begin
            sta_done_q <= 1'b0;
            sta_fail_q <= 1'b0;
            sta_irq_q <= 1'b0;
        end else if (st_q == fcp_pkg::S_FIN) begin
            sta_done_q <= 1'b1;                              // RQ21
            sta_fail_q <= fail_q;
            sta_irq_q <= mod_q[fcp_pkg::MOD_IE];             // RQ11 RQ22
        end else if (rd_clr) begin
            sta_done_q <= 1'b0;                              // RQ21
            sta_fail_q <= 1'b0;
            sta_irq_q <= 1'b0;
        end
    end

    // ========================================================
    // Checks
    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    property p_read; // RQ1
        st_q == fcp_pkg::S_RUN && cnt_q == 25'd0 && !fail_q &&
        cmd_q == fcp_pkg::CMD_READ |=> dat_q == $past(fl_rdata);
    endproperty
    a_read: assert property (p_read) else $error("read data lost");

    property p_write; // RQ2
        start && code == fcp_pkg::CMD_WRITE && wr_ok
        |=> fl_prog ##1 (busy && !fl_prog) [*8];
    endproperty
    a_write: assert property (p_write) else $error("write not run");

    property p_verify; // RQ4
        st_q == fcp_pkg::S_RUN && cnt_q == 25'd0 && !fail_q &&
        cmd_q == fcp_pkg::CMD_VERIFY
        |=> ##1 sta_fail_q == $past(verify_bad, 2);
    endproperty
    a_verify: assert property (p_verify) else $error("verify wrong");

    property p_mass_key; // RQ7
        start && code == fcp_pkg::CMD_MASS && !key_ok
        |=> !fl_erase_all ##1 st_q == fcp_pkg::S_FIN;
    endproperty
    a_mass_key: assert property (p_mass_key) else $error("mass unkeyed");

    property p_sig_len; // RQ9
        start && code == fcp_pkg::CMD_SIGN
        |=> (st_q == fcp_pkg::S_SIGN) [*8];
    endproperty
    a_sig_len: assert property (p_sig_len) else $error("sign too short");

    property p_reserved; // RQ13
        start && code == 8'h09
        |=> !(fl_prog || fl_erase_pg || fl_erase_all)
            ##2 sta_fail_q;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved ran");

    property p_con07; // RQ14
        st_q == fcp_pkg::S_FIN && cmd_q <= fcp_pkg::CMD_MASS
        |=> cmd_q == fcp_pkg::CMD_DONE;
    endproperty
    a_con07: assert property (p_con07) else $error("con not 0x07");

    property p_rdprot; // RQ15
        start && code == fcp_pkg::CMD_READ && !prot[fcp_pkg::PRO_RD]
        |=> !fl_rd ##1 $stable(dat_q);
    endproperty
    a_rdprot: assert property (p_rdprot) else $error("read unprotected");

    property p_ewgate; // RQ22
        start && code == fcp_pkg::CMD_ERASE && !mod_q[fcp_pkg::MOD_EW]
        |=> !fl_erase_pg;
    endproperty
    a_ewgate: assert property (p_ewgate) else $error("erase ungated");
endmodule : fcp_ctrl

// file: verilog/fcp_pkg.sv
// Package: register map, command codes and timing of the flash sequencer
package fcp_pkg;
    // ========================================================
    // Register offsets inside one bank; bank bit picks block
    localparam logic [6:0] OFS_STA  = 7'h00;
    localparam logic [6:0] OFS_MOD  = 7'h04;
    localparam logic [6:0] OFS_CON  = 7'h08;
    localparam logic [6:0] OFS_DAT  = 7'h0C;
    localparam logic [6:0] OFS_ADR  = 7'h10;
    localparam logic [6:0] OFS_SGN  = 7'h18;
    localparam logic [6:0] OFS_PRO  = 7'h1C;
    localparam logic [6:0] OFS_HID  = 7'h20;
    localparam int unsigned BANK_BIT = 7;
    // ========================================================
    // Command codes
    localparam logic [7:0] CMD_NULL   = 8'h00;
    localparam logic [7:0] CMD_READ   = 8'h01;
    localparam logic [7:0] CMD_WRITE  = 8'h02;
    localparam logic [7:0] CMD_ERWR   = 8'h03;
    localparam logic [7:0] CMD_VERIFY = 8'h04;
    localparam logic [7:0] CMD_ERASE  = 8'h05;
    localparam logic [7:0] CMD_MASS   = 8'h06;
    localparam logic [7:0] CMD_DONE   = 8'h07;
    localparam logic [7:0] CMD_SIGN   = 8'h0B;
    localparam logic [7:0] CMD_PROT   = 8'h0C;
    localparam logic [7:0] CMD_PING   = 8'h0F;
    // ========================================================
    // Field positions and reset values
    localparam int unsigned STA_DONE = 0;
    localparam int unsigned STA_FAIL = 1;
    localparam int unsigned STA_BUSY = 2;
    localparam int unsigned STA_IRQ  = 3;
    localparam int unsigned MOD_EW   = 3;
    localparam int unsigned MOD_IE   = 4;
    localparam int unsigned PRO_RD   = 31;
    localparam int unsigned PRO_TOP1 = 30;
    localparam logic [7:0]  MOD_RST  = 8'h80;
    localparam logic [7:0]  CON_RST  = 8'h00;
    localparam logic [15:0] ADR_RST  = 16'h0000;
    localparam logic [23:0] SGN_RST  = 24'hFFFFFF;
    localparam logic [31:0] PRO_RST  = 32'h00000000;
    localparam logic [31:0] HID_RST  = 32'hFFFFFFFF;
    localparam logic [31:0] OPEN_ALL = 32'hFFFFFFFF;
    localparam logic [15:0] MASS_DAT = 16'h3CFF;
    localparam logic [15:0] MASS_ADR = 16'hFFC3;
    localparam logic [6:0]  KERN_PG  = 7'd124;
    localparam logic [6:0]  TOP1_PG  = 7'd120;
    localparam logic [15:0] SIG_WORDS = 16'h8000;
    // ========================================================
    // Timing
    localparam longint unsigned CLK_PERIOD_NS = 100;
    localparam longint unsigned T_WRITE_US = 50;
    localparam longint unsigned T_ERWR_MS  = 20;
    localparam longint unsigned T_MASS_MS  = 2480;
    localparam longint unsigned WRITE_CYC =
        T_WRITE_US * 1000 / CLK_PERIOD_NS;
    localparam longint unsigned ERWR_CYC =
        T_ERWR_MS * 1000000 / CLK_PERIOD_NS;
    localparam longint unsigned MASS_CYC =
        T_MASS_MS * 1000000 / CLK_PERIOD_NS;
    localparam longint unsigned SIG_CYC = 32778;
    // ========================================================
    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_RUN  = 4'b0010,
        S_SIGN = 4'b0100,
        S_FIN  = 4'b1000
    } fcp_state_e;
endpackage : fcp_pkg

// file: test/fcp_flash_model.sv
// Behavioural model of the two flash arrays behind the sequencer
module fcp_flash_model (
    // Clock
    input  wire logic        clock,
    // Array strobes and operands
    input  wire logic        fl_rd,
    input  wire logic        fl_prog,
    input  wire logic        fl_erase_pg,
    input  wire logic        fl_erase_all,
    input  wire logic        fl_blk,
    input  wire logic [14:0] fl_addr,
    input  wire logic [15:0] fl_wdata,
    // Read data and count of array modifications
    output logic      [15:0] fl_rdata,
    output int               mods
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [logic [15:0]];
    logic [15:0] k;
    initial fl_rdata = 16'h0000;
    always @(posedge clock) begin
        k = {fl_blk, fl_addr};
        // Stale data is inverted every idle cycle, so it equals the last valid word only every other cycle
        fl_rdata <= fl_rd ? (mem.exists(k) ? mem[k] : 16'hFFFF) : ~fl_rdata;
        if (fl_erase_pg | fl_erase_all) begin
            mods++;
            foreach (mem[i])
                if (i[15] == fl_blk && (fl_erase_all ? (i[15] || i[14:8] < 7'd124)
                        : i[14:8] == fl_addr[14:8]))
                    mem[i] = 16'hFFFF;
        end
        if (fl_prog) begin
            mods++;
            mem[k] = fl_wdata;
        end
    end
endmodule : fcp_flash_model

// file: test/tb_fcp_ctrl.sv
// Self-checking bench of the flash command sequencer
module tb_fcp_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] B1 = 12'h080;
    logic        clock, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        fl_rd, fl_prog, fl_erase_pg, fl_erase_all, fl_blk;
    logic [14:0] fl_addr;
    logic [15:0] fl_wdata, fl_rdata;
    int          mods, m, num_errors, total_checks, cyc;
    logic [7:0]  rsv [6] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E};
    fcp_ctrl #(.ERWR_CYC(20), .MASS_CYC(30), .SIG_CYC(40)) DUT (.clock,
        .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fl_rd, .fl_prog, .fl_erase_pg, .fl_erase_all, .fl_blk,
        .fl_addr, .fl_wdata, .fl_rdata);
    fcp_flash_model MDL (.clock, .fl_rd, .fl_prog, .fl_erase_pg,
        .fl_erase_all, .fl_blk, .fl_addr, .fl_wdata, .fl_rdata, .mods);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ========================================================
    // Bus and check tasks
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) num_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic setw(input logic [11:0] b, input logic [6:0] o,
                        input logic [31:0] d);
        apb(1'b1, b | 12'(o), d);
    endtask : setw
    task automatic rchk(input logic [11:0] b, input logic [6:0] o,
                        input logic [31:0] e);
        apb(1'b0, b | 12'(o), 32'h0);
        chk(rd, e);
    endtask : rchk
    // Poll until idle; the last status read holds the outcome flags
    task automatic cmd(input logic [11:0] b, input logic [7:0] c,
                       input logic [31:0] s);
        int n = 0;
        setw(b, fcp_pkg::OFS_CON, {24'h0, c});
        do begin
            apb(1'b0, 12'h000, 32'h0);
            n++;
        end while (rd[2] !== 1'b0 && n < 200);
        chk(rd, s);
    endtask : cmd
    task automatic wrw(input logic [11:0] b, input logic [15:0] a,
                       input logic [15:0] d, input logic [7:0] c,
                       input logic [31:0] s);
        setw(b, fcp_pkg::OFS_ADR, {16'h0, a});
        setw(b, fcp_pkg::OFS_DAT, {16'h0, d});
        cmd(b, c, s);
    endtask : wrw
    task automatic rdw(input logic [11:0] b, input logic [15:0] a,
                       input logic [15:0] e);
        setw(b, fcp_pkg::OFS_ADR, {16'h0, a});
        cmd(b, fcp_pkg::CMD_READ, 32'h1);
        rchk(b, fcp_pkg::OFS_DAT, {16'h0, e});
    endtask : rdw
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ========================================================
    // Tests
    initial begin
        {psel, penable, pwrite, paddr, pwdata, srst} <= {15'h0, 32'h0, 1'b1};
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rchk(12'h0, fcp_pkg::OFS_MOD, 32'h80);
        rchk(B1, fcp_pkg::OFS_SGN, 32'hFFFFFF);
        rchk(12'h0, fcp_pkg::OFS_PRO, 32'h0);
        rchk(B1, fcp_pkg::OFS_HID, 32'hFFFFFFFF);
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset and map done");
        setw(12'h0, fcp_pkg::OFS_MOD, 32'h0);
        wrw(12'h0, 16'h0100, 16'hA5C3, fcp_pkg::CMD_WRITE, 32'h3);
        rchk(12'h0, fcp_pkg::OFS_STA, 32'h0);
        setw(12'h0, fcp_pkg::OFS_MOD, 32'h8);
        wrw(12'h0, 16'h0100, 16'hA5C3, fcp_pkg::CMD_WRITE, 32'h1);
        rchk(12'h0, fcp_pkg::OFS_CON, 32'h7);
        wrw(12'h0, 16'h0102, 16'h1111, fcp_pkg::CMD_WRITE, 32'h1);
        rdw(12'h0, 16'h0100, 16'hA5C3);
        cmd(12'h0, fcp_pkg::CMD_VERIFY, 32'h1);
        wrw(12'h0, 16'h0100, 16'h1234, fcp_pkg::CMD_VERIFY, 32'h3);
        wrw(12'h0, 16'h0100, 16'h2222, fcp_pkg::CMD_ERWR, 32'h1);
        rdw(12'h0, 16'h0102, 16'hFFFF);
        rdw(12'h0, 16'h0100, 16'h2222);
        cmd(12'h0, fcp_pkg::CMD_ERASE, 32'h1);
        rdw(12'h0, 16'h0100, 16'hFFFF);
        $display("test commands done");
        m = mods;
        setw(12'h0, fcp_pkg::OFS_HID, 32'hFFFFFFFE);
        wrw(12'h0, 16'h0100, 16'h5555, fcp_pkg::CMD_WRITE, 32'h3);
        setw(12'h0, fcp_pkg::OFS_HID, 32'h7FFFFFFF);
        cmd(12'h0, fcp_pkg::CMD_READ, 32'h3);
        setw(B1, fcp_pkg::OFS_HID, 32'hBFFFFFFF);
        wrw(B1, 16'hF000, 16'h5555, fcp_pkg::CMD_WRITE, 32'h3);
        setw(B1, fcp_pkg::OFS_HID, 32'h7FFFFFFE);
        wrw(B1, 16'h0000, 16'h5555, fcp_pkg::CMD_WRITE, 32'h3);
        cmd(B1, fcp_pkg::CMD_READ, 32'h3);
        foreach (rsv[i]) begin
            cmd(12'h0, rsv[i], 32'h3);
            rchk(12'h0, fcp_pkg::OFS_CON, 32'h0);
        end
        chk(mods, m);
        setw(12'h0, fcp_pkg::OFS_HID, 32'hFFFFFFFF);
        setw(B1, fcp_pkg::OFS_HID, 32'hFFFFFFFF);
        wrw(B1, 16'hF800, 16'h6666, fcp_pkg::CMD_WRITE, 32'h1);
        $display("test protection and reserved done");
        setw(12'h0, fcp_pkg::OFS_MOD, 32'h18);
        cmd(12'h0, fcp_pkg::CMD_PING, 32'h9);
        rchk(12'h0, fcp_pkg::OFS_CON, 32'h0);
        cmd(12'h0, fcp_pkg::CMD_NULL, 32'h9);
        rchk(12'h0, fcp_pkg::OFS_CON, 32'h7);
        setw(12'h0, fcp_pkg::OFS_MOD, 32'h8);
        MDL.mem[16'h7C00] = 16'h0BAD;
        wrw(12'h0, 16'h0200, 16'h3333, fcp_pkg::CMD_WRITE, 32'h1);
        cmd(12'h0, fcp_pkg::CMD_MASS, 32'h3);
        wrw(12'h0, 16'hFFC3, 16'h3CFF, fcp_pkg::CMD_MASS, 32'h1);
        rdw(12'h0, 16'h0200, 16'hFFFF);
        rdw(12'h0, 16'hF800, 16'h0BAD);
        cmd(12'h0, fcp_pkg::CMD_SIGN, 32'h1);
        apb(1'b0, 12'h0 | 12'(fcp_pkg::OFS_SGN), 32'h0);
        chk({31'h0, rd[31:24] === 8'h0 && rd !== 32'hFFFFFF}, 32'h1);
        setw(12'h0, fcp_pkg::OFS_PRO, 32'hFFFFFFFE);
        wrw(12'h0, 16'h1234, 16'h5678, fcp_pkg::CMD_PROT, 32'h1);
        wrw(12'h0, 16'h0100, 16'h7777, fcp_pkg::CMD_WRITE, 32'h3);
        wrw(12'h0, 16'h1234, 16'h5678, fcp_pkg::CMD_PROT, 32'h1);
        wrw(12'h0, 16'h0100, 16'h7777, fcp_pkg::CMD_WRITE, 32'h1);
        $display("test mass erase, signature and commit done");
        give_verdict();
    end
endmodule : tb_fcp_ctrl
